// ### lpdm_pkg.sv
// Package for the loop power and drive mapping block
package lpdm_pkg;

  // APB register byte addresses
  localparam logic [7:0] LPDM_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] LPDM_STATE_ADDR  = 8'h04;
  localparam logic [7:0] LPDM_ISTAT_ADDR  = 8'h08;
  localparam logic [7:0] LPDM_IEN_ADDR    = 8'h0c;
  localparam logic [7:0] LPDM_ICLR_ADDR   = 8'h10;
  localparam logic [7:0] LPDM_MAP_ADDR    = 8'h14;
  localparam logic [7:0] LPDM_IDLE_ADDR   = 8'h18;

  // Control register fields
  localparam int LPDM_CTRL_KEEP_AWAKE = 0;
  localparam int LPDM_CTRL_SERIAL_OPT = 1;
  localparam int LPDM_CTRL_LOWBAT_SD  = 2;

  // Interrupt status bit positions
  localparam int LPDM_EV_ON      = 0;
  localparam int LPDM_EV_OFF     = 1;
  localparam int LPDM_EV_LOWBAT  = 2;
  localparam int LPDM_EV_IDLE    = 3;
  localparam int LPDM_EV_NUM     = 4;

  // Reset values
  localparam logic [2:0]  LPDM_CTRL_RST = 3'h4;
  localparam logic [LPDM_EV_NUM-1:0] LPDM_IEN_RST = 4'h0;

  // Idle timeout, in microseconds, and the derived cycle count at 100 MHz
  localparam int LPDM_CLK_MHZ       = 100;
  localparam int LPDM_IDLE_US       = 1000;
  localparam int LPDM_IDLE_CYCLES   = LPDM_IDLE_US * LPDM_CLK_MHZ;

  // Memory geometry: one virtual drive per 128K bytes
  localparam int LPDM_DRIVE_KB      = 128;
  localparam logic [7:0] LPDM_ID_GOOD = 8'h47;
  localparam logic [7:0] LPDM_ID_LOW  = 8'h4c;

  // Jumper codes: bit0 = pins 1-2 bridged, bit1 = pins 2-3 bridged
  localparam logic [1:0] LPDM_JMP_MULTI  = 2'h1;
  localparam logic [1:0] LPDM_JMP_SINGLE = 2'h2;

  typedef enum logic [1:0] {
    LPDM_OFF  = 2'b00,
    LPDM_WAKE = 2'b01,
    LPDM_FULL = 2'b11,
    LPDM_LOW  = 2'b10
  } lpdm_state_t;

  // Loop-side event group
  typedef struct packed {
    logic frame;
    logic power_down;
    logic keep_awake;
  } lpdm_loop_t;

  // Drive map presented to the protocol logic
  typedef struct packed {
    logic       multi;
    logic [3:0] storage_drives;
    logic [3:0] serial_index;
    logic       serial_present;
  } lpdm_map_t;

endpackage

// ### lpdm_core.sv
// Power state and virtual drive mapping for the loop storage unit
// Operation
// - On button powers up, yellow indicator lit
// - Any loop frame while off powers up
// - Off button powers down, both indicators dark
// - Loop power-down sequence acts as off button
// - Low supply may force shutdown
// - Red indicator lit while on and battery low
// - Identity last character G good, L low
// - Idle full power drops to low power
// - Keep-awake command disables idle timeout
// - Single mode: one drive, all memory
// - Multiple mode: one drive per 128K
// - Jumper sampled at every power-on
// - Pins 1-2 multiple, pins 2-3 single
// - Serial device placed after storage drives
// - Serial device shares reference command set
`timescale 1ns/10ps
module lpdm_core
  import lpdm_pkg::*;
#(
  parameter int IDLE_CYCLES = lpdm_pkg::LPDM_IDLE_CYCLES,
  parameter int MEM_KB      = 512
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_resetn,
  // APB slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // Front panel and board
  input  wire logic               i_btn_on,
  input  wire logic               i_btn_off,
  input  wire logic               i_batt_low,
  input  wire logic [1:0]         i_jumper,
  // Loop events
  input  wire lpdm_pkg::lpdm_loop_t i_loop,
  // Outputs
  output logic                    o_led_yellow,
  output logic                    o_led_red,
  output logic                    o_full_power,
  output logic                    o_loop_active,
  output logic [7:0]              o_id_last_char,
  output lpdm_pkg::lpdm_map_t     o_map,
  output logic                    o_irq
);
  import lpdm_pkg::*;

  localparam logic [3:0] MEM_DRIVES = 4'(MEM_KB / LPDM_DRIVE_KB);

  lpdm_state_t            state;
  lpdm_state_t            next_state;
  logic [2:0]             ctrl;
  logic [LPDM_EV_NUM-1:0] istat;
  logic [LPDM_EV_NUM-1:0] ien;
  logic [LPDM_EV_NUM-1:0] ev;
  logic [31:0]            idle_cnt;
  logic                   keep_awake;
  logic                   multi_mode;
  logic                   shut_req;
  logic                   idle_hit;
  logic                   wr_en;
  logic                   rd_en;
  logic [3:0]             storage_drives;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign rd_en = i_psel && i_penable && !i_pwrite;

  // Off button, loop power-down and, with LPDM_CTRL_LOWBAT_SD set, low battery all end in the same off
  assign shut_req = i_btn_off || i_loop.power_down
                  || (i_batt_low && ctrl[LPDM_CTRL_LOWBAT_SD]);

  assign idle_hit = (idle_cnt >= 32'(IDLE_CYCLES - 1)) && !keep_awake;

  always_comb begin
    next_state = state;
    unique case (state)
      LPDM_OFF: begin
        if (!shut_req && (i_btn_on || i_loop.frame)) begin
          next_state = LPDM_WAKE;
        end
      end
      LPDM_WAKE: begin
        next_state = shut_req ? LPDM_OFF : LPDM_FULL;
      end
      LPDM_FULL: begin
        if (shut_req) begin
          next_state = LPDM_OFF;
        end else if (idle_hit && !i_loop.frame) begin
          next_state = LPDM_LOW;
        end
      end
      LPDM_LOW: begin
        if (shut_req) begin
          next_state = LPDM_OFF;
        end else if (i_loop.frame) begin
          next_state = LPDM_FULL;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= LPDM_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Idle counter restarts on any frame, held at zero outside full power
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      idle_cnt <= 32'h0;
    end else if (state != LPDM_FULL || i_loop.frame) begin
      idle_cnt <= 32'h0;
    end else if (!idle_hit) begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // Keep-awake lasts until the unit turns off; software may also set it
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      keep_awake <= 1'b0;
    end else if (state == LPDM_OFF) begin
      keep_awake <= 1'b0;
    end else if (i_loop.keep_awake || ctrl[LPDM_CTRL_KEEP_AWAKE]) begin
      keep_awake <= 1'b1;
    end
  end

  // Jumper caught on each off-to-on step, held until the next one
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      multi_mode <= 1'b0;
    end else if (state == LPDM_OFF && next_state == LPDM_WAKE) begin
      multi_mode <= (i_jumper == LPDM_JMP_MULTI);
    end
  end

  // A memory under 128K still shows one drive in multiple mode
  assign storage_drives = (multi_mode && MEM_DRIVES > 4'h1) ? MEM_DRIVES : 4'h1;

  // Serial device numbered last; its commands are handled downstream
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_map <= '0;
    end else begin
      o_map.multi          <= multi_mode;
      o_map.storage_drives <= storage_drives;
      o_map.serial_index   <= storage_drives;
      o_map.serial_present <= ctrl[LPDM_CTRL_SERIAL_OPT];
    end
  end

  // Indicators and power outputs
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_led_yellow   <= 1'b0;
      o_led_red      <= 1'b0;
      o_full_power   <= 1'b0;
      o_loop_active  <= 1'b0;
      o_id_last_char <= LPDM_ID_GOOD;
    end else begin
      o_led_yellow   <= (next_state != LPDM_OFF);
      o_led_red      <= (next_state != LPDM_OFF) && i_batt_low;
      o_full_power   <= (next_state == LPDM_WAKE) || (next_state == LPDM_FULL);
      o_loop_active  <= (next_state != LPDM_OFF);
      o_id_last_char <= i_batt_low ? LPDM_ID_LOW : LPDM_ID_GOOD;
    end
  end

  assign ev[LPDM_EV_ON]     = (state == LPDM_OFF) && (next_state == LPDM_WAKE);
  assign ev[LPDM_EV_OFF]    = (state != LPDM_OFF) && (next_state == LPDM_OFF);
  assign ev[LPDM_EV_LOWBAT] = i_batt_low;
  assign ev[LPDM_EV_IDLE]   = (state == LPDM_FULL) && (next_state == LPDM_LOW);

  // Sticky status: a new event beats a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < LPDM_EV_NUM; g++) begin : g_istat
      always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          istat[g] <= 1'b0;
        end else if (ev[g]) begin
          istat[g] <= 1'b1;
        end else if (wr_en && i_paddr == LPDM_ICLR_ADDR && i_pwdata[g]) begin
          istat[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(istat & ien);
    end
  end

  // Writable registers
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl <= LPDM_CTRL_RST;
      ien  <= LPDM_IEN_RST;
    end else if (wr_en) begin
      if (i_paddr == LPDM_CTRL_ADDR) begin
        ctrl <= i_pwdata[2:0];
      end
      if (i_paddr == LPDM_IEN_ADDR) begin
        ien <= i_pwdata[LPDM_EV_NUM-1:0];
      end
    end
  end

  // APB answers in the first access cycle; unmapped addresses error
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          LPDM_CTRL_ADDR:  o_prdata <= {29'h0, ctrl};
          LPDM_STATE_ADDR: o_prdata <= {20'h0, o_id_last_char, i_batt_low, keep_awake, state};
          LPDM_ISTAT_ADDR: o_prdata <= {28'h0, istat};
          LPDM_IEN_ADDR:   o_prdata <= {28'h0, ien};
          LPDM_ICLR_ADDR:  o_prdata <= 32'h0;
          LPDM_MAP_ADDR:   o_prdata <= {22'h0, multi_mode, storage_drives, storage_drives, ctrl[LPDM_CTRL_SERIAL_OPT]};
          LPDM_IDLE_ADDR:  o_prdata <= idle_cnt;
          default:         o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule // lpdm_core

// ### lpdm_core_properties.sv
// Concurrent checks on the power and mapping block ports
`timescale 1ns/10ps
module lpdm_core_properties
  import lpdm_pkg::*;
#(parameter int MEM_KB = 512) (
  // Clock, reset and inputs
  input wire logic                 i_sys_clk,
  input wire logic                 i_resetn,
  input wire logic                 i_psel,
  input wire logic                 i_penable,
  input wire logic                 i_btn_on,
  input wire logic                 i_btn_off,
  input wire logic                 i_batt_low,
  input wire lpdm_pkg::lpdm_loop_t i_loop,
  // Outputs
  input wire logic                 o_pready,
  input wire logic                 o_led_yellow,
  input wire logic                 o_led_red,
  input wire logic [7:0]           o_id_last_char,
  input wire lpdm_pkg::lpdm_map_t  o_map
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_on;
    o_led_yellow [*3];
  endsequence
  sequence s_wake_ok;
    !o_led_yellow && !i_btn_off && !i_loop.power_down && !i_batt_low;
  endsequence
  property p_off; i_btn_off |=> !o_led_yellow && !o_led_red; endproperty
  a_off: assert property (p_off) else $error("off button left a lamp lit");
  property p_pd; i_loop.power_down |=> !o_led_yellow && !o_led_red; endproperty
  a_pd: assert property (p_pd) else $error("power-down left unit on");
  property p_on; s_wake_ok ##0 i_btn_on |=> o_led_yellow; endproperty
  a_on: assert property (p_on) else $error("on button ignored");
  property p_frm; s_wake_ok ##0 i_loop.frame |=> o_led_yellow; endproperty
  a_frm: assert property (p_frm) else $error("frame did not wake unit");
  property p_id;
    $stable(i_batt_low) [*3] |-> o_id_last_char == (i_batt_low ? LPDM_ID_LOW : LPDM_ID_GOOD);
  endproperty
  a_id: assert property (p_id) else $error("wrong identity char");
  property p_multi; s_on ##0 o_map.multi |-> o_map.storage_drives == 4'(MEM_KB / LPDM_DRIVE_KB); endproperty
  a_multi: assert property (p_multi) else $error("bad drive count");
  property p_single; s_on ##0 !o_map.multi |-> o_map.storage_drives == 4'h1; endproperty
  a_single: assert property (p_single) else $error("single mode count");
  property p_rdy; i_psel && i_penable |-> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access phase not answered");
endmodule // lpdm_core_properties
bind lpdm_core lpdm_core_properties #(.MEM_KB(MEM_KB)) lpdm_core_properties_i (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
  .i_btn_on(i_btn_on), .i_btn_off(i_btn_off), .i_batt_low(i_batt_low), .i_loop(i_loop),
  .o_pready(o_pready), .o_led_yellow(o_led_yellow), .o_led_red(o_led_red),
  .o_id_last_char(o_id_last_char), .o_map(o_map));

// ### lpdm_loop_ctrl.sv
// Loop controller model sending frames and loop commands
`timescale 1ns/10ps
module lpdm_loop_ctrl
  import lpdm_pkg::*;
(
  input  wire logic           i_sys_clk,
  output lpdm_pkg::lpdm_loop_t o_loop
);
  initial o_loop = '0;
  // Bit 2 frame 1 power-down 0 keep-awake
  // Mode is only changed while off and media is then treated as fresh
  task automatic send(input int k);
    // At least one edge first, so a call right after another never
    // assigns the same bits twice in one time step
    repeat ($urandom_range(1, 3)) @(posedge i_sys_clk);
    o_loop[k] <= 1'b1;
    @(posedge i_sys_clk);
    o_loop <= '0;
  endtask
endmodule // lpdm_loop_ctrl

// ### testbench.sv
// Self-checking bench for the power and mapping block
`timescale 1ns/10ps
module testbench;
  import lpdm_pkg::*;
  localparam int IDLE = 20;
  logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, b_on = 0, b_off = 0, batt = 0;
  logic        pready, pslverr, yel, red, fullp, lact, irq, e;
  logic [7:0]  paddr = '0, idc;
  logic [31:0] pwdata = '0, prdata, r;
  logic [1:0]  jmp = 2'h2, j, k;
  lpdm_loop_t  loop;
  lpdm_map_t   map;
  int          fails = 0, n_tests = 0, cyc = 0;
  always #5 clk = ~clk;
  lpdm_loop_ctrl lpdm_loop_ctrl_i (.i_sys_clk(clk), .o_loop(loop));
  lpdm_core #(.IDLE_CYCLES(IDLE)) lpdm_core_i (
    .i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_btn_on(b_on), .i_btn_off(b_off), .i_batt_low(batt),
    .i_jumper(jmp), .i_loop(loop), .o_led_yellow(yel), .o_led_red(red),
    .o_full_power(fullp), .o_loop_active(lact), .o_id_last_char(idc), .o_map(map), .o_irq(irq));
  task chk(input logic [31:0] s, x);
    n_tests++;
    if (s !== x) begin
      fails++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, x);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test;
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 0;
    pen <= 0;
    // Idle edge, so a following call never rewrites psel in this step
    @(posedge clk);
  endtask
  task press(input logic off);
    if (off) b_off <= 1;
    else b_on <= 1;
    @(posedge clk);
    b_off <= 0;
    b_on <= 0;
    @(posedge clk);
  endtask
  // Expected {multi, storage drives} for a jumper code
  function logic [4:0] exp_map(input logic [1:0] c);
    return (c == LPDM_JMP_MULTI) ? {1'b1, 4'(512 / LPDM_DRIVE_KB)} : 5'h01;
  endfunction
  initial begin
    void'($urandom(59811));
    k = 2'($urandom_range(0, 3));
    repeat (4) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    chk(idc, LPDM_ID_GOOD);
    apb(0, LPDM_CTRL_ADDR, 0);
    chk(r, 32'(LPDM_CTRL_RST));
    apb(0, 8'h1c, 0);
    chk(r, 32'h0);
    chk(32'(e), 32'h1);
    apb(1, LPDM_CTRL_ADDR, 32'h2);
    apb(1, LPDM_IEN_ADDR, 32'h3);
    for (int i = 0; i < 4; i++) begin
      j = 2'(i) ^ k;
      jmp <= j;
      @(posedge clk);
      if (i % 2 == 1) press(0);
      else lpdm_loop_ctrl_i.send(2);
      repeat (2) @(posedge clk);
      chk({yel, lact}, 2'h3);
      chk({map.multi, map.storage_drives}, exp_map(j));
      chk({map.serial_present, map.serial_index >= map.storage_drives}, 2'h3);
      jmp <= ~j;
      repeat (2) @(posedge clk);
      chk({map.multi, map.storage_drives}, exp_map(j));
      if (i > 1) press(1);
      else lpdm_loop_ctrl_i.send(1);
      @(posedge clk);
      chk({yel, red}, 2'h0);
    end
    apb(0, LPDM_ISTAT_ADDR, 0);
    chk({r[1:0], irq}, 3'h7);
    apb(1, LPDM_ICLR_ADDR, 32'h3);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    press(0);
    repeat (IDLE + 5) @(posedge clk);
    chk({fullp, yel}, 2'h1);
    lpdm_loop_ctrl_i.send(2);
    repeat (2) @(posedge clk);
    chk(fullp, 1);
    repeat (4) begin
      repeat (IDLE - 8) @(posedge clk);
      lpdm_loop_ctrl_i.send(2);
    end
    chk(fullp, 1);
    lpdm_loop_ctrl_i.send(0);
    repeat (IDLE * 3) @(posedge clk);
    chk(fullp, 1);
    apb(1, LPDM_IEN_ADDR, 32'h0);
    batt <= 1;
    repeat (4) @(posedge clk);
    chk({red, idc, irq}, {1'b1, LPDM_ID_LOW, 1'b0});
    apb(1, LPDM_IEN_ADDR, 32'h4);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    batt <= 0;
    apb(1, LPDM_ICLR_ADDR, 32'hf);
    repeat (2) @(posedge clk);
    chk({irq, red}, 2'h0);
    apb(1, LPDM_CTRL_ADDR, 32'h4);
    batt <= 1;
    repeat (6) @(posedge clk);
    chk(yel, 0);
    end_of_test;
  end
endmodule // testbench
